// File: logic/scan_if.sv
`timescale 1ns/1ps
interface scan_if;
    logic [6:0] bitCount;    // Programmed bits per scan
    logic       sampleValid; // Scanned bit ready pulse
    logic [5:0] sampleIndex; // Position of that bit
    logic       sampleBit;   // Raw sampled level
    logic [5:0] outIndex;    // Output bit being presented
    logic       outBit;      // Output register bit at outIndex
    logic       scanDone;    // End of scan pulse

    modport engine (input bitCount, outBit,
                    output sampleValid, sampleIndex, sampleBit, outIndex, scanDone);
    modport core   (output bitCount, outBit,
                    input sampleValid, sampleIndex, sampleBit, outIndex, scanDone);
endinterface

// File: logic/scan_irq_pkg.sv
package scan_irq_pkg;

    // Register byte offsets, low address byte decoded
    localparam int         DEC_W              = 8;
    localparam logic [7:0] OFS_SCAN_CONFIG    = 8'h00;
    localparam logic [7:0] OFS_INPUT_POLARITY = 8'h04;
    localparam logic [7:0] OFS_REQUEST_LO     = 8'h08;
    localparam logic [7:0] OFS_REQUEST_HI     = 8'h0C;
    localparam logic [7:0] OFS_ENABLE_LO      = 8'h10;
    localparam logic [7:0] OFS_ENABLE_HI      = 8'h14;
    localparam logic [7:0] OFS_ROUTE          = 8'h18;
    localparam logic [7:0] OFS_GPO_LO         = 8'h1C;
    localparam logic [7:0] OFS_GPO_HI         = 8'h20;
    localparam logic [7:0] OFS_EVT_STATUS     = 8'h24;
    localparam logic [7:0] OFS_EVT_MASK       = 8'h28;

    // Chain geometry and field layout
    localparam int         MAX_BITS     = 64;
    localparam int         IDX_W        = 6;
    localparam int         COUNT_W      = 7;
    localparam int         NUM_STEERED  = 8;
    localparam int         ROUTE_FLD_W  = 2;
    localparam int         IRQ_LINES    = 4;
    localparam int         EVT_W        = 2;
    localparam int         EVT_SCAN_DONE_BIT = 0;
    localparam int         EVT_NEW_REQ_BIT   = 1;

    // Reset values
    localparam logic [6:0]  RST_COUNT    = 7'h40;
    localparam logic [7:0]  RST_POLARITY = 8'h00;
    localparam logic [63:0] RST_ENABLE   = 64'h0;
    localparam logic [15:0] RST_ROUTE    = 16'h0000;
    localparam logic [63:0] RST_GPO      = 64'h0;
    localparam logic [1:0]  RST_EVT_MASK = 2'h0;

    // Route field codes; code zero is the default request line 1
    localparam logic [1:0] ROUTE_LINE1 = 2'h0;
    localparam logic [1:0] ROUTE_LINE0 = 2'h1;
    localparam logic [1:0] ROUTE_LINE2 = 2'h2;
    localparam logic [1:0] ROUTE_LINE3 = 2'h3;

    // Shift clock is the system clock over four
    localparam int         CORE_CLK_NS  = 100;
    localparam int         SHIFT_DIV    = 4;
    localparam int         SHIFT_CLK_NS = CORE_CLK_NS * SHIFT_DIV;
    localparam int         PHASE_W      = 2;
    localparam logic [1:0] PHASE_FIRST  = 2'h0;
    localparam logic [1:0] PHASE_SAMPLE = 2'h1;
    localparam logic [1:0] PHASE_HIGH   = 2'h2;
    localparam logic [1:0] PHASE_LAST   = 2'(SHIFT_DIV - 1);

    // Scan sequencer states
    typedef enum logic [1:0] {
        ST_LOAD  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_LATCH = 2'b10
    } scan_state_t;

endpackage

// File: logic/scan_shift_engine.sv
`timescale 1ns/1ps
module scan_shift_engine (
    input  logic   core_clk,    // System clock
    input  logic   rst,         // Synchronous reset, active high
    scan_if.engine sif,         // Link to register core
    input  logic   serialIn,    // Serial input pin from input chain
    output logic   loadStrobeN, // Parallel load strobe, active low
    output logic   shiftClock,  // Shift clock to both chains
    output logic   serialOut,   // Serial data to output chain
    output logic   outLatch     // Output chain latch strobe
);
    scan_irq_pkg::scan_state_t state_q, state_d;           // Sequencer state
    logic [1:0] phase_q, phase_d;                          // Position in shift period
    logic [5:0] bitIdx_q, bitIdx_d;                        // Bit being shifted
    logic [5:0] prevIdx_q, prevIdx_d;                      // Bit awaiting sample
    logic       prevValid_q, prevValid_d;                  // Sample pending
    logic       sync1_q, sync2_q, sync3_q;                 // Pin synchroniser
    logic       filt_q, filt_d;                            // Agreed input level
    logic       smpValid_q, smpValid_d;                    // Sample pulse
    logic [5:0] smpIdx_q, smpIdx_d;                        // Sample position
    logic       smpBit_q, smpBit_d;                        // Sample level
    logic       done_q, done_d;                            // End of scan pulse
    logic       loadN_q, loadN_d, sclk_q, sclk_d;          // Pin flops
    logic       sout_q, sout_d, latch_q, latch_d;          // Pin flops
    logic [6:0] cntMinus;                                  // Count less one
    logic [5:0] lastIdx;                                   // Last bit of scan
    logic       periodEnd;                                 // Final phase of period

    assign sif.sampleValid = smpValid_q;
    assign sif.sampleIndex = smpIdx_q;
    assign sif.sampleBit   = smpBit_q;
    assign sif.scanDone    = done_q;
    assign sif.outIndex    = bitIdx_q;
    assign loadStrobeN     = loadN_q;
    assign shiftClock      = sclk_q;
    assign serialOut       = sout_q;
    assign outLatch        = latch_q;

    // Next state; the synchronised input lags about four cycles,
    // so bit k is taken in the sample phase of the next period.
    always_comb begin
        cntMinus    = sif.bitCount - 7'h01;
        lastIdx     = cntMinus[5:0];
        // (R4) Count limits scan
        if (sif.bitCount == 7'h00 || sif.bitCount > 7'(scan_irq_pkg::MAX_BITS)) begin
            lastIdx = 6'(scan_irq_pkg::MAX_BITS - 1);
        end
        periodEnd   = (phase_q == scan_irq_pkg::PHASE_LAST);
        // (R5) Divide by four
        phase_d     = periodEnd ? scan_irq_pkg::PHASE_FIRST : phase_q + 2'h1;
        state_d     = state_q;
        bitIdx_d    = bitIdx_q;
        prevIdx_d   = prevIdx_q;
        prevValid_d = prevValid_q;
        smpValid_d  = 1'b0;
        smpIdx_d    = smpIdx_q;
        smpBit_d    = smpBit_q;
        done_d      = 1'b0;
        sout_d      = sout_q;
        // Counts once stages two and three agree
        filt_d      = (sync2_q == sync3_q) ? sync3_q : filt_q;
        // (R3) Sample serial input
        if (state_q != scan_irq_pkg::ST_LOAD && phase_q == scan_irq_pkg::PHASE_SAMPLE
            && prevValid_q) begin
            smpValid_d = 1'b1;
            smpIdx_d   = prevIdx_q;
            smpBit_d   = filt_q;
        end
        case (state_q)
            // (R18) Strobe for one period
            scan_irq_pkg::ST_LOAD: begin
                if (periodEnd) begin
                    state_d  = scan_irq_pkg::ST_SHIFT;
                    bitIdx_d = 6'h00;
                end
            end
            scan_irq_pkg::ST_SHIFT: begin
                // (R16) Present output bit
                if (phase_q == scan_irq_pkg::PHASE_FIRST) begin
                    sout_d = sif.outBit;
                end
                if (periodEnd) begin
                    prevIdx_d   = bitIdx_q;
                    prevValid_d = 1'b1;
                    if (bitIdx_q >= lastIdx) begin
                        state_d = scan_irq_pkg::ST_LATCH;
                    end else begin
                        bitIdx_d = bitIdx_q + 6'h01;
                    end
                end
            end
            scan_irq_pkg::ST_LATCH: begin
                // (R1) Restart without software
                if (periodEnd) begin
                    prevValid_d = 1'b0;
                    done_d      = prevValid_q;
                    state_d     = scan_irq_pkg::ST_LOAD;
                end
            end
            default: begin
                state_d = scan_irq_pkg::ST_LOAD;
            end
        endcase
        // (R2) Load strobe low
        loadN_d = (state_d != scan_irq_pkg::ST_LOAD);
        sclk_d  = (state_d == scan_irq_pkg::ST_SHIFT) && (phase_d >= scan_irq_pkg::PHASE_HIGH);
        // (R18) Latch once per scan
        latch_d = (state_d == scan_irq_pkg::ST_LATCH) && (phase_d >= scan_irq_pkg::PHASE_HIGH);
    end

    // Reset at latch end: first load is a full period
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q     <= scan_irq_pkg::ST_LATCH;
            phase_q     <= scan_irq_pkg::PHASE_LAST;
            bitIdx_q    <= 6'h00;
            prevIdx_q   <= 6'h00;
            prevValid_q <= 1'b0;
            sync1_q     <= 1'b0;
            sync2_q     <= 1'b0;
            sync3_q     <= 1'b0;
            filt_q      <= 1'b0;
            smpValid_q  <= 1'b0;
            smpIdx_q    <= 6'h00;
            smpBit_q    <= 1'b0;
            done_q      <= 1'b0;
            loadN_q     <= 1'b1;
            sclk_q      <= 1'b0;
            sout_q      <= 1'b0;
            latch_q     <= 1'b0;
        end else begin
            state_q     <= state_d;
            phase_q     <= phase_d;
            bitIdx_q    <= bitIdx_d;
            prevIdx_q   <= prevIdx_d;
            prevValid_q <= prevValid_d;
            sync1_q     <= serialIn;
            sync2_q     <= sync1_q;
            sync3_q     <= sync2_q;
            filt_q      <= filt_d;
            smpValid_q  <= smpValid_d;
            smpIdx_q    <= smpIdx_d;
            smpBit_q    <= smpBit_d;
            done_q      <= done_d;
            loadN_q     <= loadN_d;
            sclk_q      <= sclk_d;
            sout_q      <= sout_d;
            latch_q     <= latch_d;
        end
    end
endmodule

// File: logic/serial_interrupt_gpio_scanner.sv
`timescale 1ns/1ps
// Functional notes
// (R1) Scan input chain continuously, up to 64
// (R2) Drive load strobe low at scan start
// (R3) Chain presents one bit per shift clock
// (R4) Programmable count sets bits per scan
// (R5) Shift clock is system clock over four
// (R6) Inputs count asserted when low by default
// (R7) Polarity bits make eight inputs active high
// (R8) Request register shows every scanned input
// (R9) Latched bit persists until next scan
// (R10) Writing one clears that request bit
// (R11) Writing all ones clears every request
// (R12) Masked inputs raise no processor request; their new-request events still reach eventIrq
// (R13) Software masks general-purpose input bits
// (R14) Sources default to request line 1
// (R15) Eight sources steerable to lines 0,2,3
// (R16) Output register shifted out continuously
// (R17) Output update delay follows scan count
// (R18) Strobe one period; latch per scan
module serial_interrupt_gpio_scanner (
    input  logic        core_clk,           // System clock, 10 MHz
    input  logic        rst,                // Synchronous reset, active high
    input  logic        hsel,               // AHB-Lite slave select
    input  logic [31:0] haddr,              // AHB-Lite address
    input  logic [1:0]  htrans,             // AHB-Lite transfer type
    input  logic        hwrite,             // AHB-Lite write flag
    input  logic [2:0]  hsize,              // AHB-Lite size, word only
    input  logic        hready,             // AHB-Lite bus ready
    input  logic [31:0] hwdata,             // AHB-Lite write data
    output logic [31:0] hrdata,             // AHB-Lite read data
    output logic        hreadyout,          // AHB-Lite slave ready
    output logic        hresp,              // AHB-Lite response, always OKAY
    input  logic        scanSerialInput,    // Serial data from input chain
    output logic        scanLoadStrobeN,    // Input chain load, active low
    output logic        scanShiftClock,     // Shift clock for both chains
    output logic        gpoSerialOutput,    // Serial data to output chain
    output logic        gpoLatchStrobe,     // Output chain latch, active high
    output logic [3:0]  irqLines,           // Processor request lines 3..0
    output logic        eventIrq            // Scanner event interrupt, level
);
    // Engine link
    scan_if sif ();

    // Software-visible state
    logic [6:0]  config_q, config_d;        // Bits per scan
    logic [7:0]  polarity_q, polarity_d;    // Active-high selects, inputs 0..7
    logic [63:0] request_q, request_d;      // Latched request state
    logic [63:0] enable_q, enable_d;        // One enables a request
    logic [15:0] route_q, route_d;          // Two bits per steered source
    logic [63:0] gpo_q, gpo_d;              // General-purpose outputs
    logic [1:0]  evtStatus_q, evtStatus_d;  // Sticky scanner events
    logic [1:0]  evtMask_q, evtMask_d;      // Event enables
    logic [3:0]  irq_q, irq_d;              // Registered request lines
    logic        evtIrq_q, evtIrq_d;        // Registered event interrupt

    // Bus slave state
    logic        wrPend_q, wrPend_d;        // Write data phase pending
    logic [7:0]  wrAddr_q, wrAddr_d;        // Latched write offset
    logic [31:0] rdData_q, rdData_d;        // Read data for data phase
    logic        accept;                    // Address phase taken
    logic        rdAccept;                  // Read address phase taken
    logic [7:0]  aOfs;                      // Decoded offset
    logic [31:0] rdMux;                     // Selected read value
    logic        sampleActive;              // Scanned bit counts as asserted
    logic        newReq;                    // Inactive-to-active transition

    // Map a route code to a request line number
    function automatic logic [1:0] routeLine(input logic [1:0] code);
        logic [1:0] line;
        line = 2'h1;
        case (code)
            scan_irq_pkg::ROUTE_LINE0: line = 2'h0;
            scan_irq_pkg::ROUTE_LINE2: line = 2'h2;
            scan_irq_pkg::ROUTE_LINE3: line = 2'h3;
            default:                   line = 2'h1;
        endcase
        return line;
    endfunction

    // Count to engine, output bit back
    assign sif.bitCount = config_q;
    assign sif.outBit   = gpo_q[sif.outIndex];

    // Shift sequencer and pin drivers
    scan_shift_engine u_engine (
        .core_clk    (core_clk),
        .rst         (rst),
        .sif         (sif),
        .serialIn    (scanSerialInput),
        .loadStrobeN (scanLoadStrobeN),
        .shiftClock  (scanShiftClock),
        .serialOut   (gpoSerialOutput),
        .outLatch    (gpoLatchStrobe)
    );

    // Outputs from flops; hreadyout and hresp tied constant
    assign hrdata    = rdData_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irqLines  = irq_q;
    assign eventIrq  = evtIrq_q;

    // Address phase; hsize ignored
    always_comb begin
        accept   = hsel && htrans[1] && hready;
        rdAccept = accept && !hwrite;
        aOfs     = haddr[scan_irq_pkg::DEC_W-1:0];
        wrPend_d = accept && hwrite;
        wrAddr_d = (accept && hwrite) ? aOfs : wrAddr_q;
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        if (aOfs == scan_irq_pkg::OFS_SCAN_CONFIG) begin
            rdMux = {25'h0, config_q};
        end else if (aOfs == scan_irq_pkg::OFS_INPUT_POLARITY) begin
            rdMux = {24'h0, polarity_q};
        // (R8) Read request state
        end else if (aOfs == scan_irq_pkg::OFS_REQUEST_LO) begin
            rdMux = request_q[31:0];
        end else if (aOfs == scan_irq_pkg::OFS_REQUEST_HI) begin
            rdMux = request_q[63:32];
        end else if (aOfs == scan_irq_pkg::OFS_ENABLE_LO) begin
            rdMux = enable_q[31:0];
        end else if (aOfs == scan_irq_pkg::OFS_ENABLE_HI) begin
            rdMux = enable_q[63:32];
        end else if (aOfs == scan_irq_pkg::OFS_ROUTE) begin
            rdMux = {16'h0, route_q};
        end else if (aOfs == scan_irq_pkg::OFS_GPO_LO) begin
            rdMux = gpo_q[31:0];
        end else if (aOfs == scan_irq_pkg::OFS_GPO_HI) begin
            rdMux = gpo_q[63:32];
        end else if (aOfs == scan_irq_pkg::OFS_EVT_STATUS) begin
            rdMux = {30'h0, evtStatus_q};
        end else if (aOfs == scan_irq_pkg::OFS_EVT_MASK) begin
            rdMux = {30'h0, evtMask_q};
        end else begin
            rdMux = 32'h0;
        end
        // Captured at the address edge so it stands through the data phase
        rdData_d = rdAccept ? rdMux : rdData_q;
    end

    // Judge each scanned bit against its polarity
    always_comb begin
        // (R6) Default active low
        sampleActive = !sif.sampleBit;
        // (R7) Active-high override
        if (sif.sampleIndex < 6'(scan_irq_pkg::NUM_STEERED)) begin
            if (polarity_q[sif.sampleIndex[2:0]]) begin
                sampleActive = sif.sampleBit;
            end
        end
        newReq = sif.sampleValid && sampleActive && !request_q[sif.sampleIndex];
    end

    // Writes, request latching, events
    always_comb begin
        config_d    = config_q;
        polarity_d  = polarity_q;
        request_d   = request_q;
        enable_d    = enable_q;
        route_d     = route_q;
        gpo_d       = gpo_q;
        evtStatus_d = evtStatus_q;
        evtMask_d   = evtMask_q;
        // Data phase of a write
        if (wrPend_q) begin
            // (R4) Program scan count
            if (wrAddr_q == scan_irq_pkg::OFS_SCAN_CONFIG) begin
                config_d = hwdata[scan_irq_pkg::COUNT_W-1:0];
            end else if (wrAddr_q == scan_irq_pkg::OFS_INPUT_POLARITY) begin
                polarity_d = hwdata[7:0];
            // (R10) Write one clears
            end else if (wrAddr_q == scan_irq_pkg::OFS_REQUEST_LO) begin
                request_d[31:0] = request_q[31:0] & ~hwdata;
            // (R11) All ones accepted
            end else if (wrAddr_q == scan_irq_pkg::OFS_REQUEST_HI) begin
                request_d[63:32] = request_q[63:32] & ~hwdata;
            end else if (wrAddr_q == scan_irq_pkg::OFS_ENABLE_LO) begin
                enable_d[31:0] = hwdata;
            end else if (wrAddr_q == scan_irq_pkg::OFS_ENABLE_HI) begin
                enable_d[63:32] = hwdata;
            end else if (wrAddr_q == scan_irq_pkg::OFS_ROUTE) begin
                route_d = hwdata[15:0];
            // (R17) Bits not yet shifted this scan take the new value
            end else if (wrAddr_q == scan_irq_pkg::OFS_GPO_LO) begin
                gpo_d[31:0] = hwdata;
            end else if (wrAddr_q == scan_irq_pkg::OFS_GPO_HI) begin
                gpo_d[63:32] = hwdata;
            end else if (wrAddr_q == scan_irq_pkg::OFS_EVT_MASK) begin
                evtMask_d = hwdata[scan_irq_pkg::EVT_W-1:0];
            end else begin
                // Status is read-only; unmapped writes are dropped
                evtMask_d = evtMask_q;
            end
        end
        // (R9) Refreshed by each scan
        // Applied after the clear, so a bit scanned active the same cycle
        // as its clear stays set and the event is not lost.
        if (sif.sampleValid) begin
            request_d[sif.sampleIndex] = sampleActive;
        end
        // Reading the status clears it
        if (rdAccept && aOfs == scan_irq_pkg::OFS_EVT_STATUS) begin
            evtStatus_d = 2'h0;
        end
        // New events win over the read clear
        if (sif.scanDone) begin
            evtStatus_d[scan_irq_pkg::EVT_SCAN_DONE_BIT] = 1'b1;
        end
        if (newReq) begin
            evtStatus_d[scan_irq_pkg::EVT_NEW_REQ_BIT] = 1'b1;
        end
    end

    // Route enabled requests to lines
    always_comb begin
        logic [1:0] line;
        line  = 2'h1;
        irq_d = 4'h0;
        for (int i = 0; i < scan_irq_pkg::MAX_BITS; i++) begin
            // (R14) Default line 1
            line = 2'h1;
            // (R15) Steer first eight
            if (i < scan_irq_pkg::NUM_STEERED) begin
                line = routeLine(route_q[i*scan_irq_pkg::ROUTE_FLD_W +: 2]);
            end
            // (R12) Mask blocks request
            if (request_q[i] && enable_q[i]) begin
                irq_d[line] = 1'b1;
            end
        end
        evtIrq_d = |(evtStatus_q & evtMask_q);
    end

    // State registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            config_q    <= scan_irq_pkg::RST_COUNT;
            polarity_q  <= scan_irq_pkg::RST_POLARITY;
            request_q   <= 64'h0;
            enable_q    <= scan_irq_pkg::RST_ENABLE;
            route_q     <= scan_irq_pkg::RST_ROUTE;
            gpo_q       <= scan_irq_pkg::RST_GPO;
            evtStatus_q <= 2'h0;
            evtMask_q   <= scan_irq_pkg::RST_EVT_MASK;
            irq_q       <= 4'h0;
            evtIrq_q    <= 1'b0;
            wrPend_q    <= 1'b0;
            wrAddr_q    <= 8'h00;
            rdData_q    <= 32'h0;
        end else begin
            config_q    <= config_d;
            polarity_q  <= polarity_d;
            request_q   <= request_d;
            enable_q    <= enable_d;
            route_q     <= route_d;
            gpo_q       <= gpo_d;
            evtStatus_q <= evtStatus_d;
            evtMask_q   <= evtMask_d;
            irq_q       <= irq_d;
            evtIrq_q    <= evtIrq_d;
            wrPend_q    <= wrPend_d;
            wrAddr_q    <= wrAddr_d;
            rdData_q    <= rdData_d;
        end
    end
endmodule

// File: test/scan_chain_model.sv
`timescale 1ns/1ps
module scan_chain_model (
    input  wire logic        loadN,     // Load, active low
    input  wire logic        shiftClk,  // Shift clock
    input  wire logic        serialIn,  // Output chain data
    input  wire logic        latch,     // Latch strobe
    input  wire logic [63:0] pins,      // Input levels
    output logic             serialOut, // Data to scanner
    output logic [63:0]      outPins    // Latched outputs
);
    logic [63:0] inSr_q;  // Input chain
    logic [63:0] outSr_q; // Output chain
    // load, then shift; ones fill in
    always @(posedge shiftClk or negedge loadN) begin
        if (!loadN)
            inSr_q <= pins;
        else
            inSr_q <= {1'b1, inSr_q[63:1]};
    end
    assign serialOut = inSr_q[0];
    // bit 0 ends in stage 0 on a 64-bit scan
    always @(posedge shiftClk) outSr_q <= {serialIn, outSr_q[63:1]};
    always @(posedge latch) outPins <= outSr_q;
endmodule

// File: test/scanner_monitor.sv
`timescale 1ns/1ps
module scanner_monitor (
    input wire logic       core_clk,        // System clock
    input wire logic       rst,             // Reset
    input wire logic       scanLoadStrobeN, // Load
    input wire logic       scanShiftClock,  // Shift clock
    input wire logic       gpoSerialOutput, // Out data
    input wire logic       gpoLatchStrobe,  // Latch
    input wire logic [3:0] irqLines,        // Requests
    input wire logic       eventIrq         // Event
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_load_quiet: assert property (!scanLoadStrobeN |-> !scanShiftClock)
        else $error("clock in load");
    a_load_width: assert property ($fell(scanLoadStrobeN) |-> !scanLoadStrobeN[*4] ##1 scanLoadStrobeN)
        else $error("load width");
    a_clk_high: assert property ($rose(scanShiftClock) |-> scanShiftClock[*2] ##1 !scanShiftClock)
        else $error("clock high");
    a_clk_low: assert property ($fell(scanShiftClock) |-> !scanShiftClock[*2])
        else $error("clock low");
    a_latch_pulse: assert property ($rose(gpoLatchStrobe) |-> ##1 gpoLatchStrobe ##1 (!gpoLatchStrobe && !scanLoadStrobeN))
        else $error("latch pulse");
    a_scan_repeat: assert property ($rose(scanLoadStrobeN) |-> ##[8:260] $fell(scanLoadStrobeN))
        else $error("no rescan");
    a_latch_still: assert property (gpoLatchStrobe |-> !scanShiftClock)
        else $error("clock in latch");
    a_data_steady: assert property (scanShiftClock |-> $stable(gpoSerialOutput))
        else $error("data moved");
    c_latch: cover property ($rose(gpoLatchStrobe));
    c_event: cover property ($rose(eventIrq));
    c_irq: cover property (irqLines != 4'h0);
endmodule
bind serial_interrupt_gpio_scanner scanner_monitor u_mon (.*);

// File: test/tb_serial_interrupt_gpio_scanner.sv
`timescale 1ns/1ps
module tb_serial_interrupt_gpio_scanner;
    logic        core_clk = 1'b0;       // Clock
    logic        rst = 1'b1;            // Reset
    logic        hsel = 1'b1;           // Bus select
    logic [31:0] haddr = 32'h0;         // Bus address
    logic [1:0]  htrans = 2'h0;         // Bus type
    logic        hwrite = 1'b0;         // Bus direction
    logic [31:0] hwdata = 32'h0;        // Bus write data
    logic [31:0] hrdata, rd;            // Read data
    logic        hreadyout, hresp;      // Slave answer
    logic        sIn, loadN, sClk, sOut, latch, eventIrq; // Chain pins and event interrupt
    logic [3:0]  irqLines;              // Request lines
    logic [63:0] pins = {64{1'b1}};     // Chain inputs
    logic [63:0] outPins;               // Chain outputs
    int          failures = 0, tests_run = 0, cycles = 0, t0;
    always #50 core_clk = ~core_clk;
    serial_interrupt_gpio_scanner u_dut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
        .scanSerialInput(sIn), .scanLoadStrobeN(loadN), .scanShiftClock(sClk),
        .gpoSerialOutput(sOut), .gpoLatchStrobe(latch), .irqLines, .eventIrq);
    scan_chain_model u_chain (.loadN, .shiftClk(sClk), .serialIn(sOut), .latch, .pins,
        .serialOut(sIn), .outPins);
    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 10000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic check(input logic [63:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        check(64'(rd), 64'(exp));
    endtask
    task automatic waitN(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Cycles per scan
    task automatic period(input int exp);
        @(negedge loadN);
        t0 = cycles;
        @(negedge loadN);
        check(64'(cycles - t0), 64'(exp));
        @(posedge core_clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d fails %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        waitN(20);
        rst <= 1'b0;
        @(posedge core_clk);
        rdChk(8'h00, 32'h40);
        rdChk(8'h04, 32'h0);
        rdChk(8'h40, 32'h0);
        $display("reset done");
        pins[3] <= 1'b0;
        pins[40] <= 1'b0;
        bus(8'h04, 1'b1, 32'h20);
        waitN(600);
        rdChk(8'h08, 32'h28);
        rdChk(8'h0C, 32'h100);
        $display("polarity done");
        @(negedge latch);
        @(posedge core_clk);
        bus(8'h08, 1'b1, 32'h8);
        rdChk(8'h08, 32'h20);
        bus(8'h0C, 1'b1, 32'hFFFFFFFF);
        rdChk(8'h0C, 32'h0);
        waitN(600);
        rdChk(8'h08, 32'h28);
        $display("clear done");
        bus(8'h10, 1'b1, 32'h8);
        for (int c = 0; c < 4; c++) begin
            bus(8'h18, 1'b1, 32'(c << 6));
            waitN(3);
            check(64'(irqLines), 64'({c == 3, c == 2, c == 0, c == 1}));
        end
        bus(8'h10, 1'b1, 32'h0);
        bus(8'h14, 1'b1, 32'h100);
        waitN(3);
        check(64'(irqLines), 64'h2);
        bus(8'h14, 1'b1, 32'h0);
        waitN(3);
        check(64'(irqLines), 64'h0);
        $display("routing done");
        bus(8'h28, 1'b1, 32'h1);
        waitN(300);
        check(64'(eventIrq), 64'h1);
        @(negedge latch);
        waitN(3);
        rdChk(8'h24, 32'h3);
        waitN(2);
        check(64'(eventIrq), 64'h0);
        bus(8'h28, 1'b1, 32'h0);
        waitN(300);
        check(64'(eventIrq), 64'h0);
        $display("events done");
        bus(8'h1C, 1'b1, 32'hA5A50F0F);
        bus(8'h20, 1'b1, 32'h12345678);
        waitN(600);
        check(outPins, 64'h12345678A5A50F0F);
        period(264);
        bus(8'h00, 1'b1, 32'h8);
        period(40);
        bus(8'h1C, 1'b1, 32'h3C);
        waitN(100);
        check(64'(outPins[63:56]), 64'h3C);
        $display("output done");
        wrap_up();
    end
endmodule
